// ---- core/eeprom_config_loader.sv ----
/*
  configuration loader: after reset, or when the host sets the load bit, reads the
  image 00..C7 from the eeprom in one sequential read, writes register bytes as they
  arrive and checks the crc. also gives the host a byte register port.
  assumes the eeprom answers at select 000 and has a pull-up on the data pin.
*/
`timescale 1ns/100ps
module eeprom_config_loader (
  input  wire logic        clk,               // core clock, 250 MHz
  input  wire logic        rst_n,             // async reset, active low
  input  wire logic        linkClk,           // link clock
  output logic             cfgSerialClockPin, // eeprom clock pin
  output logic             cfgSerialDataOut,  // eeprom data drive value
  output logic             cfgSerialDataOe,   // eeprom data drive enable
  input  wire logic        cfgSerialDataIn,   // eeprom data pin level
  input  wire logic        regSel,            // host register access strobe
  input  wire logic        regWrite,          // 1 write, 0 read
  input  wire logic [7:0]  regAddr,           // register offset
  input  wire logic [7:0]  regWdata,          // write data
  output logic [7:0]       regRdata,          // read data
  output logic             regAck,            // access done pulse
  output logic             regRefused,        // access refused pulse
  output logic             loadBusy,          // download running
  output logic             loadDone,          // last download finished
  output logic             crcError,          // last download failed its crc
  output logic             eepromAbsent,      // no acknowledge to address
  output logic             halted             // device in halted state
);
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_START1 = 4'b0001,
    ST_DEVW   = 4'b0010,
    ST_WADDR  = 4'b0011,
    ST_START2 = 4'b0100,
    ST_DEVR   = 4'b0101,
    ST_READ   = 4'b0110,
    ST_STOP   = 4'b0111,
    ST_FINISH = 4'b1000
  } load_state_type;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    load_state_type               state;     // download sequence
    logic                         pending;   // command sent, waiting for done
    logic [1:0]                   doneSync;  // done toggle synchroniser
    logic                         doneSeen;  // last done toggle taken
    logic [1:0]                   sdaSync;   // data pin synchroniser
    logic [1:0]                   sclSync;   // clock pin synchroniser
    logic                         reqTgl;    // request toggle
    cfg_loader_pkg::link_cmd_type cmd;       // command payload
    logic [7:0]                   wdata;     // write payload
    logic                         ackBit;    // read acknowledge payload
    logic [7:0]                   idx;       // image byte being read
    logic [31:0]                  crc;       // running crc
    logic [31:0]                  crcStored; // crc bytes from the eeprom
    logic                         absent;    // address not acknowledged
    logic [cfg_loader_pkg::IMAGE_BYTES-1:0][7:0] image; // register bytes
    logic [7:0]                   rdata;     // host read data
    logic                         ack;       // host access pulse
    logic                         refused;   // host refusal pulse
    logic                         busy;      // download running
    logic                         done;      // download finished
    logic                         crcErr;    // crc mismatch
    logic                         halted;    // halted state
  } load_type;

  load_type                     s;
  load_type                     next_s;
  cfg_loader_pkg::link_cmd_type stepCmd;  // command of the current step
  logic [7:0]                   stepData; // byte of the current step
  logic                         doneEvt;  // engine finished a command
  link_cmd_if                   link ();

  // ethernet crc, bytes least significant bit first as in a frame
  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ cfg_loader_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  // each step sends one command, then waits for the done toggle before moving on
  always_comb begin
    next_s         = s;
    next_s.ack     = 1'b0;
    next_s.refused = 1'b0;
    next_s.doneSync = {s.doneSync[0], link.doneTgl};
    next_s.sdaSync  = {s.sdaSync[0], cfgSerialDataIn};
    next_s.sclSync  = {s.sclSync[0], link.sclState};
    doneEvt  = (s.doneSync[1] != s.doneSeen);
    stepCmd  = cfg_loader_pkg::CMD_START;
    stepData = cfg_loader_pkg::FIRST_ADDR;
    case (s.state)
      ST_DEVW: begin
        stepCmd  = cfg_loader_pkg::CMD_WRITE;
        stepData = cfg_loader_pkg::SLAVE_WRITE;
      end
      ST_WADDR: stepCmd = cfg_loader_pkg::CMD_WRITE;
      ST_DEVR: begin
        stepCmd  = cfg_loader_pkg::CMD_WRITE;
        stepData = cfg_loader_pkg::SLAVE_READ;
      end
      ST_READ: stepCmd = cfg_loader_pkg::CMD_READ;
      ST_STOP: stepCmd = cfg_loader_pkg::CMD_STOP;
      default: stepCmd = cfg_loader_pkg::CMD_START;
    endcase
    if (s.state != ST_IDLE && s.state != ST_FINISH) begin
      if (!s.pending) begin
        next_s.pending = 1'b1;
        next_s.reqTgl  = ~s.reqTgl;
        next_s.cmd     = stepCmd;
        next_s.wdata   = stepData;
        next_s.ackBit  = (s.idx == cfg_loader_pkg::LAST_BYTE); // last byte not acked
      end else if (doneEvt) begin
        next_s.pending  = 1'b0;
        next_s.doneSeen = s.doneSync[1];
        case (s.state)
          ST_START1: next_s.state = ST_DEVW;
          ST_DEVW, ST_WADDR, ST_DEVR: begin
            if (link.nack) begin
              next_s.absent = 1'b1;
              next_s.state  = ST_STOP;
            end else if (s.state == ST_DEVW) begin
              next_s.state = ST_WADDR;
            end else if (s.state == ST_WADDR) begin
              next_s.state = ST_START2;
            end else begin
              next_s.state = ST_READ;
              next_s.idx   = cfg_loader_pkg::FIRST_ADDR;
              next_s.crc   = cfg_loader_pkg::CRC_INIT;
            end
          end
          ST_START2: next_s.state = ST_DEVR;
          ST_READ: begin
            // bytes land at their own offset: port records, queue lengths,
            // globals, vlan words, ram size, then system control last
            if (s.idx < cfg_loader_pkg::CRC_FIRST) begin
              next_s.image[s.idx] = link.rdata;
              next_s.crc          = crcByte(s.crc, link.rdata);
            end else begin
              next_s.crcStored = {s.crcStored[23:0], link.rdata};
            end
            if (s.idx == cfg_loader_pkg::LAST_BYTE) begin
              next_s.state = ST_STOP;
            end else begin
              next_s.idx = s.idx + 8'h01;
            end
          end
          default: next_s.state = ST_FINISH;
        endcase
      end
    end else if (s.state == ST_FINISH) begin
      next_s.state = ST_IDLE;
      next_s.busy  = 1'b0;
      next_s.done  = 1'b1;
      if (s.absent || (s.crcStored != ~s.crc)) begin
        // a bad or missing image must not half-configure the switch
        next_s.image  = {cfg_loader_pkg::IMAGE_BYTES{cfg_loader_pkg::DEFAULT_BYTE}};
        next_s.halted = 1'b1;
        next_s.crcErr = ~s.absent;
      end else begin
        next_s.halted = ~s.image[cfg_loader_pkg::SYS_CTRL][cfg_loader_pkg::START_BIT];
        next_s.image[cfg_loader_pkg::SYS_CTRL][cfg_loader_pkg::LOAD_BIT] = 1'b0;
      end
    end
    // host register port
    if (regSel) begin
      if (s.busy) begin
        next_s.refused = 1'b1;
      end else begin
        next_s.ack   = 1'b1;
        next_s.rdata = 8'h00;
        if (regAddr == cfg_loader_pkg::PIN_CTRL) begin
          // pin levels, not the stored bits, so the host sees the eeprom answer
          next_s.rdata = s.image[regAddr];
          next_s.rdata[cfg_loader_pkg::PIN_DATA_BIT] = s.sdaSync[1];
          next_s.rdata[cfg_loader_pkg::PIN_CLK_BIT]  = s.sclSync[1];
        end else if (regAddr < cfg_loader_pkg::IMAGE_BYTES) begin
          next_s.rdata = s.image[regAddr];
        end
        if (regWrite && regAddr < cfg_loader_pkg::IMAGE_BYTES) begin
          next_s.image[regAddr] = regWdata;
          if (regAddr == cfg_loader_pkg::SYS_CTRL) begin
            if (regWdata[cfg_loader_pkg::START_BIT]) begin
              next_s.halted = 1'b0;
            end
            if (regWdata[cfg_loader_pkg::LOAD_BIT]) begin
              next_s.state  = ST_START1;
              next_s.busy   = 1'b1;
              next_s.done   = 1'b0;
              next_s.absent = 1'b0;
              next_s.crcErr = 1'b0;
            end
          end
        end
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // reset starts a download at once and leaves the device halted until it ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s        <= '0;
      s.state  <= ST_START1;
      s.busy   <= 1'b1;
      s.halted <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // link side
  // ************************************************************
  assign link.reqTgl   = s.reqTgl;
  assign link.cmd      = s.cmd;
  assign link.wdata    = s.wdata;
  assign link.ackBit   = s.ackBit;
  assign link.autoMode = s.busy;
  assign link.hostClk  = s.image[cfg_loader_pkg::PIN_CTRL][cfg_loader_pkg::PIN_CLK_BIT];
  assign link.hostData = s.image[cfg_loader_pkg::PIN_CTRL][cfg_loader_pkg::PIN_DATA_BIT];
  assign link.hostOe   = s.image[cfg_loader_pkg::PIN_CTRL][cfg_loader_pkg::PIN_OE_BIT];

  serial_link_engine engine (
    .linkClk (linkClk),
    .rst_n   (rst_n),
    .sdaIn   (cfgSerialDataIn),
    .sclPin  (cfgSerialClockPin),
    .sdaOut  (cfgSerialDataOut),
    .sdaOe   (cfgSerialDataOe),
    .link    (link.eng)
  );

  assign regRdata     = s.rdata;
  assign regAck       = s.ack;
  assign regRefused   = s.refused;
  assign loadBusy     = s.busy;
  assign loadDone     = s.done;
  assign crcError     = s.crcErr;
  assign eepromAbsent = s.absent;
  assign halted       = s.halted;
endmodule

// ---- core/serial_link_engine.sv ----
/*
  two-wire serial engine on the link clock: start, stop, byte write and byte read,
  four link clocks per bit. when the loader is idle the pins follow the host bits.
  assumes link_cmd_if payload stays stable while a request toggle is outstanding.
*/
`timescale 1ns/100ps
module serial_link_engine (
  input  wire logic   linkClk,  // link clock
  input  wire logic   rst_n,    // async reset, active low
  input  wire logic   sdaIn,    // data pin level
  output logic        sclPin,   // clock pin
  output logic        sdaOut,   // data pin drive value
  output logic        sdaOe,    // data pin drive enable
  link_cmd_if.eng     link      // carrier to the loader
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0]                   reqSync;    // request toggle synchroniser
    logic                         reqSeen;    // last toggle taken
    logic [1:0]                   autoSync;   // mode synchroniser
    logic [2:0]                   hostMeta;   // host bits, first stage
    logic [2:0]                   hostStable; // host bits, second stage
    logic [1:0]                   sdaSync;    // data pin synchroniser
    logic                         busy;       // command running
    cfg_loader_pkg::link_cmd_type cmd;        // running command
    logic [8:0]                   shift;      // byte plus ninth bit
    logic [3:0]                   bitCnt;     // bit within the byte
    logic [1:0]                   phase;      // quarter of a bit
    logic                         scl;        // clock pin
    logic                         sdaOut;     // data drive value
    logic                         sdaOe;      // data drive enable
    logic                         doneTgl;    // completion toggle
    logic [7:0]                   rdata;      // byte read
    logic                         nack;       // ninth bit sampled
  } eng_state_type;

  eng_state_type s;
  eng_state_type next_s;
  logic          writing;  // write command drives its eight data bits

  // ************************************************************
  // next state
  // ************************************************************
  // one bit: phase 0 sets data, 1 raises clock, 2 holds it, 3 lowers it and samples.
  // the pin synchroniser lags two link clocks, so the level taken at phase 3 is the
  // one that stood after the data edge and before the clock rose; a bit still driven
  // from the previous phase can never leak into the sample.
  // data only changes while clock is low, so no false start or stop appears.
  always_comb begin
    next_s            = s;
    writing           = (s.cmd == cfg_loader_pkg::CMD_WRITE);
    next_s.reqSync    = {s.reqSync[0], link.reqTgl};
    next_s.autoSync   = {s.autoSync[0], link.autoMode};
    next_s.hostMeta   = {link.hostClk, link.hostData, link.hostOe};
    next_s.hostStable = s.hostMeta;
    next_s.sdaSync    = {s.sdaSync[0], sdaIn};
    if (!s.busy) begin
      if (s.reqSync[1] != s.reqSeen) begin
        // take a new command
        next_s.reqSeen = s.reqSync[1];
        next_s.busy    = 1'b1;
        next_s.cmd     = link.cmd;
        next_s.phase   = 2'h0;
        next_s.bitCnt  = 4'h0;
        if (link.cmd == cfg_loader_pkg::CMD_WRITE) begin
          next_s.shift = {link.wdata, 1'b1};
        end else begin
          next_s.shift = {8'hff, link.ackBit};
        end
      end else if (!s.autoSync[1]) begin
        // host bit-bang: pins are a direct reflection of the host bits
        next_s.scl    = s.hostStable[2];
        next_s.sdaOut = s.hostStable[1];
        next_s.sdaOe  = s.hostStable[0];
      end
    end else begin
      next_s.phase = s.phase + 2'h1;
      case (s.cmd)
        cfg_loader_pkg::CMD_START: begin
          case (s.phase)
            2'h0: begin
              next_s.scl    = 1'b0;
              next_s.sdaOut = 1'b1;
              next_s.sdaOe  = 1'b1;
            end
            2'h1: next_s.scl = 1'b1;
            2'h2: next_s.sdaOut = 1'b0; // data falls with clock high
            default: begin
              next_s.scl     = 1'b0;
              next_s.busy    = 1'b0;
              next_s.doneTgl = ~s.doneTgl;
            end
          endcase
        end
        cfg_loader_pkg::CMD_STOP: begin
          case (s.phase)
            2'h0: next_s.scl = 1'b0;
            2'h1: begin
              next_s.sdaOut = 1'b0;
              next_s.sdaOe  = 1'b1;
            end
            2'h2: next_s.scl = 1'b1;
            default: begin
              next_s.sdaOut  = 1'b1; // data rises with clock high
              next_s.busy    = 1'b0;
              next_s.doneTgl = ~s.doneTgl;
            end
          endcase
        end
        default: begin
          case (s.phase)
            2'h0: begin
              // data bits driven on write, released on read; ninth bit reversed
              if (writing) begin
                next_s.sdaOe = (s.bitCnt < cfg_loader_pkg::BYTE_BITS);
              end else begin
                next_s.sdaOe = (s.bitCnt == cfg_loader_pkg::BYTE_BITS);
              end
              next_s.sdaOut = s.shift[8];
            end
            2'h1: next_s.scl = 1'b1;
            2'h2: next_s.scl = 1'b1; // clock held high for a second phase
            default: begin
              next_s.scl    = 1'b0;
              next_s.shift  = {s.shift[7:0], s.sdaSync[1]};
              next_s.bitCnt = s.bitCnt + 4'h1;
              if (s.bitCnt == cfg_loader_pkg::BYTE_BITS) begin
                next_s.rdata   = next_s.shift[8:1];
                next_s.nack    = next_s.shift[0];
                next_s.busy    = 1'b0;
                next_s.doneTgl = ~s.doneTgl;
              end
            end
          endcase
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // pins idle with clock high and data released
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.scl <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sclPin        = s.scl;
  assign sdaOut        = s.sdaOut;
  assign sdaOe         = s.sdaOe;
  assign link.doneTgl  = s.doneTgl;
  assign link.rdata    = s.rdata;
  assign link.nack     = s.nack;
  assign link.sclState = s.scl;
endmodule

// ---- shared/cfg_loader_pkg.sv ----
/*
  shared constants and types for the serial configuration loader: image layout, slave
  address bytes, register offsets, control bit positions and link commands.
  assumes a single 8-bit host register port and a two-wire eeprom on the link pins.
*/
// Functional notes
// - clock pin always driven; data direction follows transfer
// - slave address begins with type 1010
// - device select bits are 000
// - read address byte ends with direction 1
// - pin control bits mirror clock and data pins
// - eight-byte port records up to byte 77
// - two-byte queue lengths from 80 to 9D
// - A0-A2 globals, VLAN words from A4
// - port 14 VLAN C0-C1, C2, C3 last
// - check image against ethernet 32-bit CRC
// - CRC failure restores defaults and halts
// - every byte sent most significant bit first
// - refuse host access during load; clear load
package cfg_loader_pkg;
  // ************************************************************
  // image layout
  // ************************************************************
  localparam int          IMAGE_BYTES  = 196;          // register bytes 00..C3
  localparam logic [7:0]  FIRST_ADDR   = 8'h00;        // first image byte
  localparam logic [7:0]  CRC_FIRST    = 8'hc4;        // first stored crc byte
  localparam logic [7:0]  LAST_BYTE    = 8'hc7;        // last byte fetched
  localparam logic [7:0]  PIN_CTRL     = 8'ha1;        // serial_eeprom_pin_control
  localparam logic [7:0]  SYS_CTRL     = 8'hc3;        // system control byte
  localparam logic [7:0]  DEFAULT_BYTE = 8'h00;        // hardwired register default
  // ************************************************************
  // control bit positions
  // ************************************************************
  localparam int          PIN_DATA_BIT = 0;            // data_mirror_bit
  localparam int          PIN_CLK_BIT  = 1;            // clock_mirror_bit
  localparam int          PIN_OE_BIT   = 2;            // host data drive enable
  localparam int          START_BIT    = 0;            // leave halted state
  localparam int          LOAD_BIT     = 1;            // request a new download
  // ************************************************************
  // link constants
  // ************************************************************
  localparam logic [7:0]  SLAVE_WRITE  = 8'ha0;        // 1010, select 000, write
  localparam logic [7:0]  SLAVE_READ   = 8'ha1;        // 1010, select 000, read
  localparam logic [31:0] CRC_POLY     = 32'hedb88320; // reflected ethernet polynomial
  localparam logic [31:0] CRC_INIT     = 32'hffffffff; // crc preset
  localparam logic [3:0]  BYTE_BITS    = 4'h8;         // index of the acknowledge bit

  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ  = 2'b10,
    CMD_STOP  = 2'b11
  } link_cmd_type;
endpackage

// ---- shared/link_cmd_if.sv ----
/*
  command carrier between the loader control (core clock) and the serial engine
  (link clock). assumes toggle handshakes: payload is held stable while a request
  toggle is outstanding, results are held stable after the done toggle.
*/
`timescale 1ns/100ps
interface link_cmd_if;
  logic                        reqTgl;   // toggles once per command
  cfg_loader_pkg::link_cmd_type cmd;     // command code
  logic [7:0]                  wdata;    // byte to write
  logic                        ackBit;   // acknowledge level sent after a read
  logic                        doneTgl;  // toggles when a command ends
  logic [7:0]                  rdata;    // byte read
  logic                        nack;     // level seen in the ninth bit
  logic                        autoMode; // loader owns the pins
  logic                        hostClk;  // host clock_mirror_bit
  logic                        hostData; // host data_mirror_bit
  logic                        hostOe;   // host data drive enable
  logic                        sclState; // clock pin level as driven

  modport ctrl (output reqTgl, cmd, wdata, ackBit, autoMode, hostClk, hostData, hostOe,
                input  doneTgl, rdata, nack, sclState);
  modport eng  (input  reqTgl, cmd, wdata, ackBit, autoMode, hostClk, hostData, hostOe,
                output doneTgl, rdata, nack, sclState);
endinterface

// ---- sim/eeprom_config_loader_chk.sv ----
/* checker on the loader's top ports: register answers and download status.
   assumes it is bound into eeprom_config_loader from the bench top. */
`timescale 1ns/100ps
module eeprom_config_loader_chk (
  input wire logic       clk, rst_n, regSel, regWrite,           // clock, reset, access
  input wire logic [7:0] regAddr, regWdata, regRdata,            // access bytes
  input wire logic       regAck, regRefused, loadBusy, loadDone, // answers
  input wire logic       crcError, eepromAbsent, halted          // status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctl; // idle write of the system control byte
  assign ctl = regSel && regWrite && !loadBusy && regAddr == cfg_loader_pkg::SYS_CTRL;
  sequence s_take; regSel && !loadBusy; endsequence
  sequence s_ok; regAck && !regRefused; endsequence
  a_ack_taken: assert property (s_take |=> s_ok)
    else $error("access not acknowledged");
  a_refuse_busy: assert property (regSel && loadBusy |=> regRefused && !regAck)
    else $error("busy access not refused");
  a_answer_cause: assert property (regAck || regRefused |-> $past(regSel))
    else $error("answer without access");
  a_rdata_hold: assert property (!regAck |-> $stable(regRdata))
    else $error("read data moved");
  a_load_start: assert property (ctl && regWdata[1] |=> loadBusy && !loadDone)
    else $error("load did not start");
  a_start_run: assert property (ctl && regWdata[1:0] == 2'b01 |-> ##[1:2] !halted)
    else $error("start did not run");
  a_end_status: assert property ($fell(loadBusy) |-> loadDone || crcError || eepromAbsent)
    else $error("load ended without status");
  a_fail_halt: assert property ($rose(crcError) || $rose(eepromAbsent) |-> halted)
    else $error("failed load left device running");
endmodule

// ---- sim/eeprom_config_loader_tb_top.sv ----
/* bench top: loader and eeprom model on a pulled-up data wire.
   assumes the package and the design files are compiled first. */
`timescale 1ns/100ps
module eeprom_config_loader_tb_top;
  logic clk = 0, linkClk = 0, rst_n = 0, regSel = 0, regWrite = 0, present = 1;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, a, d, img [196]; // img: expected
  logic scl, dOut, dOe, pullLow, regAck, regRefused, loadBusy, loadDone, crcError;
  logic eepromAbsent, halted;
  logic [31:0] c; // crc accumulator
  int err_count = 0, n_checks = 0, seed = 68, i;
  wire sda = (dOe ? dOut : 1'b1) & !pullLow; // pull-up when released
  always #2 clk = !clk;
  initial #1.3 forever #80 linkClk = !linkClk;
  eeprom_config_loader uut (.clk, .rst_n, .linkClk, .cfgSerialClockPin(scl),
    .cfgSerialDataOut(dOut), .cfgSerialDataOe(dOe), .cfgSerialDataIn(sda), .regSel,
    .regWrite, .regAddr, .regWdata, .regRdata, .regAck, .regRefused, .loadBusy,
    .loadDone, .crcError, .eepromAbsent, .halted);
  eeprom_model eep (.scl, .sda, .present, .pullLow);
  task report_and_stop;
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [7:0] ad, dt, e, input logic r);
    @(posedge clk);
    regSel <= 1'b1;
    regWrite <= w;
    regAddr <= ad;
    regWdata <= dt;
    @(posedge clk);
    regSel <= 1'b0;
    #1;
    chk({regAck, regRefused}, {!r, r});
    if (!w && !r) chk(regRdata, e);
  endtask
  task load(input logic [7:0] ad);
    if (ad == 8'hc3) acc(1'b1, ad, 8'h02, 8'h00, 1'b0);
    for (i = 0; i < 400000 && loadBusy !== 1'b0; i++) @(posedge clk);
    chk(loadBusy, 0);
    if (loadBusy !== 1'b0) report_and_stop;
  endtask
  initial begin
    c = 32'hffffffff;
    for (i = 0; i < 196; i++) begin
      img[i] = 8'($random(seed));
      if (i == 161) img[i] = img[i] & 8'hf8 | 8'h03; // pins idle after load
      if (i == 195) img[i] = img[i] & 8'hfc; // stay halted, no reload
      c = c ^ {24'h0, img[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      eep.mem[i] = img[i];
    end
    for (i = 0; i < 4; i++) eep.mem[196 + i] = 8'(~c >> (24 - 8 * i));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b1, 8'hc3, 8'h02, 8'h00, 1'b1);
    load(8'h00);
    chk({loadDone, crcError, eepromAbsent, halted}, 4'b1001);
    for (a = 0; a < 8'hc4; a++) acc(1'b0, a, 8'h00, img[a], 1'b0);
    acc(1'b1, 8'hc3, 8'h01, 8'h00, 1'b0);
    repeat (2) @(posedge clk);
    chk(halted, 0);
    repeat (6) begin
      {a, d} = 16'($random(seed));
      acc(1'b1, a % 8'ha0, d, 8'h00, 1'b0);
      acc(1'b0, a % 8'ha0, 8'h00, d, 1'b0);
      acc(1'b0, 8'hc4 + a % 8'h3c, 8'h00, 8'h00, 1'b0);
    end
    acc(1'b1, 8'ha1, 8'h04, 8'h00, 1'b0);
    repeat (200) @(posedge clk);
    chk({scl, dOe, dOut}, 3'b010);
    acc(1'b0, 8'ha1, 8'h00, 8'h04, 1'b0);
    acc(1'b1, 8'ha1, 8'h03, 8'h00, 1'b0);
    eep.mem[5] = eep.mem[5] ^ 8'h10;
    load(8'hc3);
    chk({crcError, halted, eepromAbsent}, 3'b110);
    acc(1'b0, 8'h05, 8'h00, 8'h00, 1'b0);
    present <= 1'b0;
    load(8'hc3);
    chk({eepromAbsent, crcError, halted}, 3'b101);
    report_and_stop;
  end
endmodule
bind eeprom_config_loader eeprom_config_loader_chk chk_i (.clk, .rst_n, .regSel, .regWrite,
  .regAddr, .regWdata, .regRdata, .regAck, .regRefused, .loadBusy, .loadDone, .crcError,
  .eepromAbsent, .halted);

// ---- sim/eeprom_model.sv ----
/* two-wire eeprom model: answers at select 000, random and sequential reads.
   assumes a pull-up on the data wire; present low makes it silent. */
`timescale 1ns/100ps
module eeprom_model (
  input wire logic scl,     // clock pin
  input wire logic sda,     // resolved data wire
  input wire logic present, // low: never acknowledges
  output logic     pullLow  // pulls data low
);
  logic [7:0] mem [256], sh, ptr; // storage, shifter, address
  int n = 0, st = 9; // bit count; 0 addr, 1 word, 2 write, 4 read, 9 idle
  initial pullLow = 0;
  always @(negedge sda) if (scl) {n, st} = 64'h0;
  always @(posedge sda) if (scl) st = 9;
  always @(posedge scl) begin
    if (st != 4 && n < 8) sh = {sh[6:0], sda};
    if (st == 4 && n == 8 && sda) st = 9; // master ends the read
    n = n + 1;
  end
  // data only moves while the clock is low
  always @(negedge scl) begin
    pullLow = 0;
    if (n == 8 && st < 4 && present) begin
      case (st)
        0: st = sh[7:1] != 7'h50 ? 9 : sh[0] ? 4 : 1;
        1: {ptr, st} = {sh, 32'd2};
        default: ;
      endcase
      pullLow = st != 9;
    end
    if (n == 9) n = 0;
    if (n == 0 && st == 4) {sh, ptr} = {mem[ptr], ptr + 8'h01};
    if (st == 4 && n < 8) pullLow = !sh[7 - n];
  end
endmodule
